// File: inc/adpcm_enc_defines.vh
// constants of the adpcm quantizer and scale factor adaptation core
// assumes inclusion by bare name from every design file that needs it
`ifndef ADPCM_ENC_DEFINES_VH
`define ADPCM_ENC_DEFINES_VH

// =====================================================================
// timing
`define CLK_PERIOD_NS      10
`define SAMPLE_PERIOD_NS   125000

// =====================================================================
// companding
`define LAW_MU             1'b0
`define LAW_A              1'b1
`define MU_INVERT          8'hff
`define A_INVERT           8'h55
`define EXP_BIAS           6'h21
`define MU_BIAS            14'h0021

// =====================================================================
// quantizer decision thresholds on dln, 1/128 units, signed 12 bit
`define THR_1              12'hf84
`define THR_2              12'h050
`define THR_3              12'h0b2
`define THR_4              12'h0f6
`define THR_5              12'h12c
`define THR_6              12'h15d
`define THR_7              12'h190

// =====================================================================
// inverse quantizer log outputs, 1/128 units
`define DQLN_0             12'h800
`define DQLN_1             12'h004
`define DQLN_2             12'h087
`define DQLN_3             12'h0d5
`define DQLN_4             12'h111
`define DQLN_5             12'h143
`define DQLN_6             12'h175
`define DQLN_7             12'h1a9

// =====================================================================
// scale factor weights, 1/16 units
`define WI_0               12'hff4
`define WI_1               12'h012
`define WI_2               12'h029
`define WI_3               12'h040
`define WI_4               12'h070
`define WI_5               12'h0c6
`define WI_6               12'h163
`define WI_7               12'h462

// =====================================================================
// scale factor limits and reset values
`define YU_MIN             13'h0220
`define YU_MAX             13'h1400
`define YU_RESET           13'h0220
`define YL_RESET           19'h08800
`define AP_RESET           10'h000
`define AP_LIMIT           10'h100
`define AL_ONE             7'h40

`endif

// File: src/two_entry_buffer.v
// two-entry valid/ready buffer for the encoder's output words
// assumes one clock and an active-low asynchronous reset
`timescale 1ns/1ps

module two_entry_buffer #(
   parameter WIDTH = 49
) (
   // clock and reset
   input  wire             clk_sys_in,
   input  wire             reset_n_in,
   // fill side
   input  wire             fill_valid_in,
   output wire             fill_ready_out,
   input  wire [WIDTH-1:0] fill_data_in,
   // drain side
   output wire             drain_valid_out,
   input  wire             drain_ready_in,
   output wire [WIDTH-1:0] drain_data_out
);

   reg  [WIDTH-1:0] head_r;
   reg  [WIDTH-1:0] tail_r;
   reg  [1:0]       count_r;
   wire             push;
   wire             pop;

   assign fill_ready_out  = (count_r != 2'h2);
   assign drain_valid_out = (count_r != 2'h0);
   assign drain_data_out  = head_r;
   assign push = fill_valid_in & fill_ready_out;
   assign pop  = drain_valid_out & drain_ready_in;

   // =====================================================================
   // storage: head always holds the oldest word
   always @(posedge clk_sys_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         head_r  <= {WIDTH{1'b0}};
         tail_r  <= {WIDTH{1'b0}};
         count_r <= 2'h0;
      end else begin
         if (push && !pop) begin
            count_r <= count_r + 2'h1;
            if (count_r == 2'h0)
               head_r <= fill_data_in;
            else
               tail_r <= fill_data_in;
         end else if (pop && !push) begin
            count_r <= count_r - 2'h1;
            head_r  <= tail_r;
         end else if (pop && push) begin
            // with one entry the new word moves straight to the head
            if (count_r == 2'h1)
               head_r <= fill_data_in;
            else begin
               head_r <= tail_r;
               tail_r <= fill_data_in;
            end
         end
      end
   end

endmodule // two_entry_buffer

// File: src/adpcm_quantizer_scale_adapt.v
// adpcm encoder core: pcm expansion, adaptive quantizer, inverse
// quantizer, reconstruction and bimodal scale factor adaptation.
// assumes the predictor, speed control and tone logic sit outside and
// present the signal estimate and speed value on the same clock.
//
// How it works
// - pcm byte, a-law or mu-law by law_sel_in, becomes 4-bit code.
// - one sample per strobe; strobes faster than 125 us are flagged.
// - compressed byte is expanded to 14-bit uniform pcm.
// - difference is uniform sample minus signal estimate.
// - fifteen levels coded as sign plus three magnitude bits.
// - difference magnitude goes to log2, scale factor subtracted.
// - log value picks magnitude 7..0 against fixed thresholds.
// - each threshold belongs to the interval above it.
// - magnitude maps to log output, plus scale, then back to linear.
// - code is emitted and feeds inverse quantizer and adaptation.
// - fast factor: 31/32 of y plus w/32, clamped 1.06..10.00.
// - weight table per magnitude code.
// - slow factor: 63/64 old plus 1/64 new fast factor.
// - y mixes previous fast and slow factors by speed al.
// - reconstructed sample is estimate plus quantized difference.
// - arithmetic follows the fixed-point reference sequence exactly.
// - speed al is previous speed value capped at one.
`timescale 1ns/1ps
`include "adpcm_enc_defines.vh"

module adpcm_quantizer_scale_adapt #(
   parameter SAMPLE_CYCLES = (`SAMPLE_PERIOD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS
) (
   // clock and reset
   input  wire        clk_sys_in,
   input  wire        reset_n_in,
   // pcm sample side
   input  wire        sample_valid_in,
   output wire        sample_ready_out,
   input  wire [7:0]  pcm_byte_in,
   input  wire        law_sel_in,
   input  wire [14:0] estimate_in,
   output reg         rate_error_out,
   // speed value from the speed control
   input  wire        speed_valid_in,
   input  wire [9:0]  speed_in,
   // coded output side
   output wire        code_valid_out,
   input  wire        code_ready_in,
   output wire [3:0]  code_out,
   output wire [15:0] dq_out,
   output wire [15:0] recon_out,
   output wire [12:0] scale_out,
   // slow scale factor for the tone logic
   output reg  [18:0] slow_scale_out
);

   localparam CNT_W = 14;
   localparam [CNT_W-1:0] SAMPLE_CNT = SAMPLE_CYCLES[CNT_W-1:0];

   // =====================================================================
   // state
   reg  [12:0]      yu_r;
   reg  [18:0]      yl_r;
   reg  [9:0]       ap_r;
   reg  [CNT_W-1:0] gap_cnt_r;
   wire             accept;
   wire             buf_ready;

   assign sample_ready_out = buf_ready;
   assign accept = sample_valid_in & buf_ready;

   // =====================================================================
   // leading one position of a 15-bit magnitude
   function [3:0] msb_pos;
      input [14:0] v;
      integer i;
      begin
         msb_pos = 4'h0;
         for (i = 0; i < 15; i = i + 1)
            if (v[i])
               msb_pos = i[3:0];
      end
   endfunction

   // =====================================================================
   // expansion
   reg  [7:0]  pcm_x;
   reg  [2:0]  pexp;
   reg  [5:0]  pseg;
   reg  [13:0] mag14;
   reg  [13:0] sl;
   always @* begin
      pcm_x = 8'h00;
      pexp  = 3'h0;
      pseg  = 6'h00;
      mag14 = 14'h0000;
      sl    = 14'h0000;
      if (law_sel_in == `LAW_MU) begin
         pcm_x = pcm_byte_in ^ `MU_INVERT;
         pexp  = pcm_x[6:4];
         pseg  = {1'b0, pcm_x[3:0], 1'b0} + `EXP_BIAS;
         mag14 = ({8'h00, pseg} << pexp) - `MU_BIAS;
         sl    = pcm_x[7] ? (14'h0000 - mag14) : mag14;
      end else begin
         pcm_x = pcm_byte_in ^ `A_INVERT;
         pexp  = pcm_x[6:4];
         if (pexp == 3'h0)
            mag14 = {8'h00, pcm_x[3:0], 2'h2};
         else begin
            pseg  = {1'b0, pcm_x[3:0], 1'b0} + `EXP_BIAS;
            mag14 = {7'h00, pseg, 1'b0} << (pexp - 3'h1);
         end
         sl = pcm_x[7] ? mag14 : (14'h0000 - mag14);
      end
   end

   // =====================================================================
   // mix of fast and slow factors
   reg  [6:0]  al;
   reg  [13:0] mdif;
   reg  [12:0] mdifm;
   reg  [19:0] mprod_full;
   reg  [12:0] mprodm;
   reg  [12:0] mprod;
   reg  [12:0] y;
   always @* begin
      if (ap_r >= `AP_LIMIT)
         al = `AL_ONE;
      else
         al = ap_r[8:2];
      // scale the magnitude, then restore the sign, so truncation is symmetric
      mdif  = {1'b0, yu_r} - {1'b0, yl_r[18:6]};
      mdifm = mdif[13] ? (13'h0000 - mdif[12:0]) : mdif[12:0];
      mprod_full = mdifm * al;
      mprodm = mprod_full[18:6];
      mprod  = mdif[13] ? (13'h0000 - mprodm) : mprodm;
      y      = yl_r[18:6] + mprod;
   end

   // =====================================================================
   // difference, log and quantizer
   reg  [15:0] d;
   reg  [14:0] dm;
   reg  [3:0]  dexp;
   reg  [21:0] dshift;
   reg  [10:0] dl;
   reg  [11:0] dln;
   reg  [2:0]  imag;
   reg  [3:0]  code;
   always @* begin
      d      = {sl[13], sl[13], sl} - {estimate_in[14], estimate_in};
      dm     = d[15] ? (15'h0000 - d[14:0]) : d[14:0];
      dexp   = msb_pos(dm);
      dshift = {dm, 7'h00} >> dexp;
      dl     = {dexp, dshift[6:0]};
      dln    = {1'b0, dl} - {1'b0, y[12:2]};
      // signed compares, each threshold starts its own interval
      if ($signed(dln) < $signed(`THR_1))
         imag = 3'h0;
      else if ($signed(dln) < $signed(`THR_2))
         imag = 3'h1;
      else if ($signed(dln) < $signed(`THR_3))
         imag = 3'h2;
      else if ($signed(dln) < $signed(`THR_4))
         imag = 3'h3;
      else if ($signed(dln) < $signed(`THR_5))
         imag = 3'h4;
      else if ($signed(dln) < $signed(`THR_6))
         imag = 3'h5;
      else if ($signed(dln) < $signed(`THR_7))
         imag = 3'h6;
      else
         imag = 3'h7;
      // negative difference sends the ones complement of the magnitude
      code = d[15] ? {1'b1, ~imag} : {1'b0, imag};
   end

   // =====================================================================
   // inverse quantizer and reconstruction
   reg  [11:0] dqln;
   reg  [11:0] dql;
   reg  [7:0]  dqt;
   reg  [14:0] dqmag;
   reg  [15:0] dq;
   reg  [15:0] dq_tc;
   reg  [15:0] sr;
   always @* begin
      case (imag)
         3'h0: dqln = `DQLN_0;
         3'h1: dqln = `DQLN_1;
         3'h2: dqln = `DQLN_2;
         3'h3: dqln = `DQLN_3;
         3'h4: dqln = `DQLN_4;
         3'h5: dqln = `DQLN_5;
         3'h6: dqln = `DQLN_6;
         default: dqln = `DQLN_7;
      endcase
      dql = dqln + {1'b0, y[12:2]};
      // y is capped, so the exponent never passes fourteen
      dqt = {1'b1, dql[6:0]};
      // a negative log value means the linear magnitude is zero
      if (dql[11])
         dqmag = 15'h0000;
      else
         dqmag = {dqt, 7'h00} >> (4'he - dql[10:7]);
      dq    = {code[3], dqmag};
      dq_tc = code[3] ? (16'h0000 - {1'b0, dqmag}) : {1'b0, dqmag};
      sr    = dq_tc + {estimate_in[14], estimate_in};
   end

   // =====================================================================
   // fast and slow factor updates
   reg  [11:0] wi;
   reg  [16:0] fdif;
   reg  [12:0] fdifsx;
   reg  [12:0] yut;
   reg  [12:0] yu_nxt;
   reg  [13:0] ldif;
   reg  [18:0] yl_nxt;
   always @* begin
      case (imag)
         3'h0: wi = `WI_0;
         3'h1: wi = `WI_1;
         3'h2: wi = `WI_2;
         3'h3: wi = `WI_3;
         3'h4: wi = `WI_4;
         3'h5: wi = `WI_5;
         3'h6: wi = `WI_6;
         default: wi = `WI_7;
      endcase
      // subtract before shifting; reordering changes the low bits and breaks lockstep
      fdif   = {wi, 5'h00} - {4'h0, y};
      fdifsx = {fdif[16], fdif[16:5]};
      yut    = y + fdifsx;
      if (yut < `YU_MIN)
         yu_nxt = `YU_MIN;
      else if (yut >= `YU_MAX)
         yu_nxt = `YU_MAX;
      else
         yu_nxt = yut;
      ldif   = {1'b0, yu_nxt} - {1'b0, yl_r[18:6]};
      yl_nxt = yl_r + {{5{ldif[13]}}, ldif};
   end

   // =====================================================================
   // state registers; factors update once per accepted sample, speed value on speed_valid_in
   always @(posedge clk_sys_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         yu_r           <= `YU_RESET;
         yl_r           <= `YL_RESET;
         ap_r           <= `AP_RESET;
         slow_scale_out <= `YL_RESET;
      end else begin
         if (accept) begin
            yu_r           <= yu_nxt;
            yl_r           <= yl_nxt;
            slow_scale_out <= yl_nxt;
         end
         // a sample taken in the same cycle still sees the old speed value
         if (speed_valid_in)
            ap_r <= speed_in;
      end
   end

   // =====================================================================
   // sample spacing watch; early samples are still coded, only flagged
   always @(posedge clk_sys_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         gap_cnt_r      <= SAMPLE_CNT;
         rate_error_out <= 1'b0;
      end else begin
         // counter saturates, so the first sample after reset is never flagged
         rate_error_out <= accept && (gap_cnt_r < SAMPLE_CNT - 14'h0001);
         if (accept)
            gap_cnt_r <= {CNT_W{1'b0}};
         else if (gap_cnt_r != SAMPLE_CNT)
            gap_cnt_r <= gap_cnt_r + 14'h0001;
      end
   end

   // =====================================================================
   // output buffer; a stalled channel holds off the sample source
   // word order: code, quantized difference, reconstruction, scale
   wire [48:0] out_word;
   two_entry_buffer #(
      .WIDTH (49)
   ) u_out_buf (
      .clk_sys_in      (clk_sys_in),
      .reset_n_in      (reset_n_in),
      .fill_valid_in   (sample_valid_in),
      .fill_ready_out  (buf_ready),
      .fill_data_in    ({code, dq, sr, y}),
      .drain_valid_out (code_valid_out),
      .drain_ready_in  (code_ready_in),
      .drain_data_out  (out_word)
   );

   assign code_out  = out_word[48:45];
   assign dq_out    = out_word[44:29];
   assign recon_out = out_word[28:13];
   assign scale_out = out_word[12:0];

endmodule // adpcm_quantizer_scale_adapt

// File: bench/adpcm_monitor.sv
// checker of the encoder core port behaviour
// assumes binding to the encoder core top module
`timescale 1ns/1ps
module adpcm_monitor (
   // clock and reset
   input wire        clk_sys_in,
   input wire        reset_n_in,
   // handshakes
   input wire        sample_valid_in,
   input wire        sample_ready_out,
   input wire        code_valid_out,
   input wire        code_ready_in,
   input wire        rate_error_out,
   // coded word
   input wire [3:0]  code_out,
   input wire [15:0] dq_out,
   input wire [12:0] scale_out,
   input wire [18:0] slow_scale_out
);
   // ==========
   // helpers
   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (!reset_n_in);
   wire       acc = sample_valid_in && sample_ready_out;
   // negative codes carry a complemented magnitude
   wire [2:0] mag = code_out[3] ? ~code_out[2:0] : code_out[2:0];
   // ==========
   // assertions
   AST_ANSWER: assert property (acc && !code_valid_out |=> code_valid_out)
      else $error("no word one cycle after a sample into an empty buffer");
   AST_REFUSE: assert property (!sample_ready_out |-> code_valid_out)
      else $error("sample refused with no word waiting");
   AST_HOLD: assert property (code_valid_out && !code_ready_in |=>
      code_valid_out && $stable({code_out, dq_out, scale_out}))
      else $error("stalled word changed or vanished");
   AST_RATE: assert property (rate_error_out |-> $past(acc))
      else $error("rate flag without a preceding accept");
   AST_SCALE: assert property (code_valid_out |->
      scale_out >= 13'h0220 && scale_out <= 13'h1400)
      else $error("scale factor outside its limits");
   AST_ZERO: assert property (code_valid_out && mag == 3'h0 |-> dq_out[14:0] == 15'h0)
      else $error("zero magnitude gave nonzero difference");
   AST_LEVEL: assert property (code_valid_out && mag != 3'h0 |->
      dq_out[14:0] != 15'h0 && dq_out[15] == code_out[3])
      else $error("difference magnitude or sign disagrees with code");
   AST_SLOW: assert property (!$stable(slow_scale_out) |-> $past(acc))
      else $error("slow factor moved without a sample");
   // ==========
   // covers
   cover property (acc);
   cover property (!sample_ready_out);
   cover property (rate_error_out);
endmodule // adpcm_monitor

bind adpcm_quantizer_scale_adapt adpcm_monitor u_mon (
   .clk_sys_in       (clk_sys_in),
   .reset_n_in       (reset_n_in),
   .sample_valid_in  (sample_valid_in),
   .sample_ready_out (sample_ready_out),
   .code_valid_out   (code_valid_out),
   .code_ready_in    (code_ready_in),
   .rate_error_out   (rate_error_out),
   .code_out         (code_out),
   .dq_out           (dq_out),
   .scale_out        (scale_out),
   .slow_scale_out   (slow_scale_out)
);

// File: bench/pcm_link_model.sv
// pcm sample source and coded word sink facing the encoder core
// assumes callers enter its tasks 1 ns after a rising edge
`timescale 1ns/1ps
module pcm_link_model (
   // clock
   input  wire        clk_sys_in,
   // sample side
   input  wire        sample_ready_out,
   output reg         sample_valid_in,
   output reg  [7:0]  pcm_byte_in,
   output reg         law_sel_in,
   output reg  [14:0] estimate_in,
   // coded side
   input  wire        code_valid_out,
   output reg         code_ready_in,
   input  wire [3:0]  code_out,
   input  wire [15:0] dq_out,
   input  wire [15:0] recon_out,
   input  wire [12:0] scale_out
);
   reg          stall = 1'b0;
   logic [48:0] got[$];
   initial begin
      sample_valid_in = 1'b0;
      pcm_byte_in = 8'h00;
      law_sel_in = 1'b0;
      estimate_in = 15'h0000;
      code_ready_in = 1'b1;
   end
   // ==========
   // source: request held until a ready edge takes it
   task send(input [7:0] b, input l, input [14:0] e);
      sample_valid_in = 1'b1;
      pcm_byte_in = b;
      law_sel_in = l;
      estimate_in = e;
      while (!sample_ready_out) @(posedge clk_sys_in) #1;
      @(posedge clk_sys_in) #1;
   endtask
   // released lines flip so a stale byte never looks valid
   task idle;
      sample_valid_in = 1'b0;
      pcm_byte_in = ~pcm_byte_in;
      estimate_in = ~estimate_in;
      repeat (10) @(posedge clk_sys_in) #1;
   endtask
   // ==========
   // sink
   always @(posedge clk_sys_in) begin
      if (code_valid_out && code_ready_in)
         got.push_back({code_out, dq_out, recon_out, scale_out});
      code_ready_in <= #1 !stall;
   end
endmodule // pcm_link_model

// File: bench/tb_adpcm_quantizer_scale_adapt.sv
// self-checking bench of the adpcm encoder core
// assumes the core, its buffer, monitor and link model are compiled first
`timescale 1ns/1ps
module tb_adpcm_quantizer_scale_adapt;
   reg          clk_sys_in;
   reg          reset_n_in;
   reg          speed_valid_in;
   reg  [9:0]   speed_in;
   wire         sample_valid_in;
   wire         sample_ready_out;
   wire [7:0]   pcm_byte_in;
   wire         law_sel_in;
   wire [14:0]  estimate_in;
   wire         rate_error_out;
   wire         code_valid_out;
   wire         code_ready_in;
   wire [3:0]   code_out;
   wire [15:0]  dq_out;
   wire [15:0]  recon_out;
   wire [12:0]  scale_out;
   wire [18:0]  slow_scale_out;
   integer      num_errors = 0;
   integer      compares = 0;
   integer      i;
   logic [48:0] w;
   // short sample spacing keeps the rate watch cheap to reach
   adpcm_quantizer_scale_adapt #(.SAMPLE_CYCLES(8)) u_dut (.clk_sys_in(clk_sys_in),
      .reset_n_in(reset_n_in), .sample_valid_in(sample_valid_in),
      .sample_ready_out(sample_ready_out), .pcm_byte_in(pcm_byte_in),
      .law_sel_in(law_sel_in), .estimate_in(estimate_in), .rate_error_out(rate_error_out),
      .speed_valid_in(speed_valid_in), .speed_in(speed_in), .code_valid_out(code_valid_out),
      .code_ready_in(code_ready_in), .code_out(code_out), .dq_out(dq_out),
      .recon_out(recon_out), .scale_out(scale_out), .slow_scale_out(slow_scale_out));
   pcm_link_model u_link (.clk_sys_in(clk_sys_in), .sample_ready_out(sample_ready_out),
      .sample_valid_in(sample_valid_in), .pcm_byte_in(pcm_byte_in), .law_sel_in(law_sel_in),
      .estimate_in(estimate_in), .code_valid_out(code_valid_out),
      .code_ready_in(code_ready_in), .code_out(code_out), .dq_out(dq_out),
      .recon_out(recon_out), .scale_out(scale_out));
   initial begin
      clk_sys_in = 1'b0;
      forever #5 clk_sys_in = ~clk_sys_in;
   end
   // ==========
   // checking and closing
   task check(input [63:0] seen, input [63:0] exp);
      compares = compares + 1;
      if (seen !== exp) begin
         num_errors = num_errors + 1;
         $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task stop_test;
      if (num_errors == 0 && compares > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task get(output [48:0] x);
      repeat (20) if (u_link.got.size() == 0) @(posedge clk_sys_in) #1;
      check(u_link.got.size() != 0, 1'b1);
      x = u_link.got.pop_front();
   endtask
   // ==========
   // scenarios
   task t_reset;
      check(slow_scale_out, 19'h08800);
      check({sample_ready_out, code_valid_out, rate_error_out}, 3'h4);
   endtask
   // full scale both laws; y moves 0x220 -> yu 0x671 once speed caps at one
   task t_law;
      u_link.send(8'h80, 1'b0, 15'h0000);
      check(rate_error_out, 1'b0);
      u_link.idle;
      get(w);
      check({w[48:45], w[44]}, 5'h0e);
      check(w[44:29], 16'h0016);
      check(w[28:13], 16'h0016);
      check(w[12:0], 13'h0220);
      check(slow_scale_out, 19'h08c51);
      speed_valid_in = 1'b1;
      speed_in = 10'h3ff;
      @(posedge clk_sys_in) #1;
      speed_valid_in = 1'b0;
      u_link.send(8'h2a, 1'b1, 15'h0000);
      u_link.idle;
      get(w);
      check(w[48:45], 4'h8);
      check(w[12:0], 13'h0671);
      check(w[44:13], {16'h8062, 16'hff9e});
   endtask
   // difference of one sits below the lowest threshold
   task t_zero;
      u_link.send(8'hff, 1'b0, 15'h7fff);
      u_link.idle;
      get(w);
      check(w[48:13], {4'h0, 16'h0000, 16'hffff});
   endtask
   task t_rate;
      u_link.send(8'hff, 1'b0, 15'h7fff);
      check(rate_error_out, 1'b0);
      u_link.send(8'hff, 1'b0, 15'h7ffe);
      check(rate_error_out, 1'b1);
      u_link.idle;
      get(w);
      get(w);
   endtask
   // third sample must wait while the sink stalls, none lost
   task t_stall;
      u_link.stall = 1'b1;
      @(posedge clk_sys_in) #1;
      fork
         begin
            u_link.send(8'hff, 1'b0, 15'h7fff);
            u_link.send(8'hff, 1'b0, 15'h7ffe);
            u_link.send(8'hff, 1'b0, 15'h7ffd);
            u_link.idle;
         end
         begin
            repeat (6) @(posedge clk_sys_in) #1;
            check(sample_ready_out, 1'b0);
            check(u_link.got.size(), 0);
            u_link.stall = 1'b0;
         end
      join
      for (i = 0; i < 3; i = i + 1) begin
         get(w);
         check(w[28:13], 16'hffff - i);
      end
      check(code_valid_out, 1'b0);
   endtask
   // mid-run reset puts y back on its floor, so the top threshold is hit exactly
   task t_edge;
      reset_n_in = 1'b0;
      repeat (2) @(posedge clk_sys_in) #1;
      reset_n_in = 1'b1;
      t_reset;
      u_link.send(8'hff, 1'b0, 15'h7fed);
      u_link.idle;
      get(w);
      check(w[48:13], {4'h7, 16'h0016, 16'h0003});
      check(w[12:0], 13'h0220);
      u_link.send(8'hff, 1'b0, 15'h7fee);
      u_link.idle;
      get(w);
      check(w[48:13], {4'h6, 16'h0010, 16'hfffe});
      check(w[12:0], 13'h0231);
      check(slow_scale_out, 19'h08da2);
   endtask
   // ==========
   // main sequence and watchdog
   initial begin
      reset_n_in = 1'b0;
      speed_valid_in = 1'b0;
      speed_in = 10'h000;
      repeat (2) @(posedge clk_sys_in);
      #1 reset_n_in = 1'b1;
      t_reset;
      t_law;
      t_zero;
      t_rate;
      t_stall;
      t_edge;
      stop_test;
   end
   initial begin
      #100000;
      num_errors = num_errors + 1;
      stop_test;
   end
endmodule // tb_adpcm_quantizer_scale_adapt
